// *** ssp_pkg.sv ***
// constants and types for the switchgear position supervisor
package ssp_pkg;
	// ========================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_T_CLOSE = 8'h04;
	localparam logic [7:0] ADDR_T_OPEN = 8'h08;
	localparam logic [7:0] ADDR_T_SETTLE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	// ========================================
	// fields
	localparam int CFG_CLOSE_WIRED = 0;
	localparam int CFG_OPEN_WIRED = 1;
	localparam int ST_CODE_LSB = 0;
	localparam int ST_AT_CLOSED = 2;
	localparam int ST_AT_OPEN = 3;
	localparam int ST_IN_TRANSIT = 4;
	localparam int ST_DISTURBED = 5;
	localparam int ST_FAULT = 6;
	localparam int ST_ONE_CONTACT = 7;
	localparam int ST_CLOSE_DRIVE = 8;
	localparam int ST_OPEN_DRIVE = 9;
	// ========================================
	// reset values and timing
	localparam logic [1:0] CFG_RESET = 2'h3;
	localparam int CLOCK_MHZ = 100;
	localparam int TRAVEL_TIME_US = 10;
	localparam int TRAVEL_CYCLES = TRAVEL_TIME_US * CLOCK_MHZ;
	localparam logic [31:0] T_TRAVEL_RESET = 32'(TRAVEL_CYCLES);
	localparam logic [31:0] T_SETTLE_RESET = 32'h0;
	// ========================================
	// position codes
	localparam logic [1:0] POS_INDETERM = 2'h0;
	localparam logic [1:0] POS_OPEN = 2'h1;
	localparam logic [1:0] POS_CLOSED = 2'h2;
	localparam logic [1:0] POS_DISTURBED = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_MOVE_CLOSE = 4'h2,
		ST_MOVE_OPEN = 4'h4,
		ST_SETTLE = 4'h8
	} ssp_state_t;
endpackage

// *** ssp_supervisor.sv ***
// switchgear position supervisor with avalon-mm register slave
// Overview of operation
// - both aux contacts are sampled every cycle and position re-evaluated continuously
// - two-bit code: 0 indeterminate, 1 open, 2 closed, 3 disturbed, plus four flags
// - close command runs close timer; closed feedback gives closed, expiry gives fault
// - open command runs open timer; open feedback gives open, expiry gives fault
// - both wired: 10 closed, 01 open, equal in-transit while moving, else disturbed
// - one-contact flag is set when exactly one contact is configured
// - single contact supervises only the direction of the wired contact
// - closed-only: reaching closed in time gives closed and success, transit drops same cycle
// - closed-only expiry: fault, then settle shown in transit, then closed
// - closed-only decode: 1 closed, 0 in-transit while close timer runs, else open
// - open-only: reaching open in time gives open and success, transit drops same cycle
// - open-only expiry: fault, then settle shown in transit, then open
// - open-only decode: 1 open, 0 in-transit while open timer runs, else closed
// - no contact assigned forces code disturbed
// - three interlocks per direction; any active one blocks that direction
// - protection open and auto reclose bypass interlocks; only block input stops trip
// - drive output lasts at most the travel time, ends early on new position
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module ssp_supervisor (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	input wire logic aux_closed_i,
	input wire logic aux_open_i,
	input wire logic close_cmd_i,
	input wire logic open_cmd_i,
	input wire logic prot_open_i,
	input wire logic prot_block_i,
	input wire logic auto_reclose_i,
	input wire logic [2:0] interlock_close_i,
	input wire logic [2:0] interlock_open_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	output logic [1:0] pos_code_o,
	output logic at_closed_o,
	output logic at_open_o,
	output logic in_transit_o,
	output logic disturbed_o,
	output logic travel_fault_o,
	output logic one_contact_flag_o,
	output logic command_done_ok_o,
	output logic close_drive_o,
	output logic open_drive_o
);
	// ========================================
	// helpers
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic expired(input logic [31:0] cnt, input logic [31:0] preset);
		// count starts at zero, so the last cycle of the period is preset-1
		return ({1'b0, cnt} + 33'h1) >= {1'b0, preset};
	endfunction
	function automatic logic [1:0] pos_decode(input logic cw, input logic ow, input logic cl,
			input logic op, input logic mv_c, input logic mv_o);
		if (cw && ow) begin
			if (cl != op) begin
				return cl ? ssp_pkg::POS_CLOSED : ssp_pkg::POS_OPEN;
			end
			return (mv_c || mv_o) ? ssp_pkg::POS_INDETERM : ssp_pkg::POS_DISTURBED;
		end else if (cw) begin
			return cl ? ssp_pkg::POS_CLOSED :
				(mv_c ? ssp_pkg::POS_INDETERM : ssp_pkg::POS_OPEN);
		end else if (ow) begin
			return op ? ssp_pkg::POS_OPEN :
				(mv_o ? ssp_pkg::POS_INDETERM : ssp_pkg::POS_CLOSED);
		end
		return ssp_pkg::POS_DISTURBED;
	endfunction
	// ========================================
	// contact synchronisers
	logic [2:0] cl_sync;
	logic [2:0] op_sync;
	logic cl_in;
	logic op_in;
	// a change counts once the second and third stage agree
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cl_sync <= 3'h0;
			op_sync <= 3'h0;
			cl_in <= 1'b0;
			op_in <= 1'b0;
		end else begin
			cl_sync <= {cl_sync[1:0], aux_closed_i};
			op_sync <= {op_sync[1:0], aux_open_i};
			if (cl_sync[2] == cl_sync[1]) begin
				cl_in <= cl_sync[2];
			end
			if (op_sync[2] == op_sync[1]) begin
				op_in <= op_sync[2];
			end
		end
	end
	// ========================================
	// registers
	logic [1:0] cfg;
	logic [31:0] t_close;
	logic [31:0] t_open;
	logic [31:0] t_settle;
	logic req;
	logic [31:0] status;
	assign req = read_i || write_i;
	assign status = {22'h0, open_drive_o, close_drive_o, one_contact_flag_o, travel_fault_o,
		disturbed_o, in_transit_o, at_open_o, at_closed_o, pos_code_o};

	// one wait cycle, so read data is settled a full cycle before it is taken
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h0;
		end else begin
			waitrequest_o <= !(req && waitrequest_o);
			if (read_i && waitrequest_o) begin
				case (address_i)
					ssp_pkg::ADDR_CFG: readdata_o <= {30'h0, cfg};
					ssp_pkg::ADDR_T_CLOSE: readdata_o <= t_close;
					ssp_pkg::ADDR_T_OPEN: readdata_o <= t_open;
					ssp_pkg::ADDR_T_SETTLE: readdata_o <= t_settle;
					ssp_pkg::ADDR_STATUS: readdata_o <= status;
					default: readdata_o <= 32'h0;
				endcase
			end
		end
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cfg <= ssp_pkg::CFG_RESET;
			t_close <= ssp_pkg::T_TRAVEL_RESET;
			t_open <= ssp_pkg::T_TRAVEL_RESET;
			t_settle <= ssp_pkg::T_SETTLE_RESET;
		end else if (write_i && !waitrequest_o) begin
			case (address_i)
				ssp_pkg::ADDR_CFG: cfg <= byteenable_i[0] ? writedata_i[1:0] : cfg;
				ssp_pkg::ADDR_T_CLOSE: t_close <= be_merge(t_close, writedata_i, byteenable_i);
				ssp_pkg::ADDR_T_OPEN: t_open <= be_merge(t_open, writedata_i, byteenable_i);
				ssp_pkg::ADDR_T_SETTLE: t_settle <= be_merge(t_settle, writedata_i, byteenable_i);
				default: ;
			endcase
		end
	end
	// ========================================
	// command acceptance and travel supervision
	ssp_pkg::ssp_state_t state;
	ssp_pkg::ssp_state_t next_state;
	logic [31:0] count;
	logic [31:0] next_count;
	logic force_v;
	logic next_force_v;
	logic [1:0] force_code;
	logic [1:0] next_force_code;
	logic next_fault;
	logic next_done;
	logic [1:0] next_code;
	logic cw;
	logic ow;
	logic single;
	logic il_close;
	logic il_open;
	logic start_open;
	logic start_close;
	logic reach_close;
	logic reach_open;

	assign cw = cfg[ssp_pkg::CFG_CLOSE_WIRED];
	assign ow = cfg[ssp_pkg::CFG_OPEN_WIRED];
	assign single = cw ^ ow;
	assign il_close = |interlock_close_i;
	assign il_open = |interlock_open_i;
	// a protection trip may cut into a running close; nothing else overlaps a move
	assign start_open = !at_open_o && state != ssp_pkg::ST_MOVE_OPEN &&
		((prot_open_i && !prot_block_i) ||
		(state == ssp_pkg::ST_IDLE && open_cmd_i && !il_open));
	assign start_close = state == ssp_pkg::ST_IDLE && !start_open && !at_closed_o &&
		(auto_reclose_i || (close_cmd_i && !il_close));
	// unwired side falls back to the other contact reading inactive
	assign reach_close = cw ? (cl_in && !(ow && op_in)) : !op_in;
	assign reach_open = ow ? (op_in && !(cw && cl_in)) : !cl_in;

	always_comb begin
		next_state = state;
		next_count = count + 32'h1;
		next_force_v = force_v;
		next_force_code = force_code;
		next_fault = travel_fault_o;
		next_done = 1'b0;
		if (start_open || start_close) begin
			next_state = start_open ? ssp_pkg::ST_MOVE_OPEN : ssp_pkg::ST_MOVE_CLOSE;
			next_count = 32'h0;
			next_fault = 1'b0;
			next_force_v = 1'b0;
		end else begin
			case (state)
				ssp_pkg::ST_MOVE_CLOSE: begin
					if (reach_close) begin
						next_state = ssp_pkg::ST_IDLE;
						next_done = cw;
					end else if (expired(count, t_close)) begin
						next_state = ssp_pkg::ST_IDLE;
						next_fault = cw;
						next_force_code = ssp_pkg::POS_CLOSED;
						if (cw && single) begin
							next_count = 32'h0;
							if (t_settle != 32'h0) begin
								next_state = ssp_pkg::ST_SETTLE;
							end else begin
								next_force_v = 1'b1;
							end
						end
					end
				end
				ssp_pkg::ST_MOVE_OPEN: begin
					if (reach_open) begin
						next_state = ssp_pkg::ST_IDLE;
						next_done = ow;
					end else if (expired(count, t_open)) begin
						next_state = ssp_pkg::ST_IDLE;
						next_fault = ow;
						next_force_code = ssp_pkg::POS_OPEN;
						if (ow && single) begin
							next_count = 32'h0;
							if (t_settle != 32'h0) begin
								next_state = ssp_pkg::ST_SETTLE;
							end else begin
								next_force_v = 1'b1;
							end
						end
					end
				end
				ssp_pkg::ST_SETTLE: begin
					if (expired(count, t_settle)) begin
						next_state = ssp_pkg::ST_IDLE;
						next_force_v = 1'b1;
					end
				end
				ssp_pkg::ST_IDLE: next_count = 32'h0;
				default: next_state = ssp_pkg::ST_IDLE;
			endcase
		end
		if (!cw && !ow) begin
			next_code = ssp_pkg::POS_DISTURBED;
		end else if (next_state == ssp_pkg::ST_SETTLE) begin
			next_code = ssp_pkg::POS_INDETERM;
		end else if (next_force_v) begin
			next_code = next_force_code;
		end else begin
			next_code = pos_decode(cw, ow, cl_in, op_in, next_state == ssp_pkg::ST_MOVE_CLOSE,
				next_state == ssp_pkg::ST_MOVE_OPEN);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ssp_pkg::ST_IDLE;
			count <= 32'h0;
			force_v <= 1'b0;
			force_code <= ssp_pkg::POS_INDETERM;
			travel_fault_o <= 1'b0;
			command_done_ok_o <= 1'b0;
			close_drive_o <= 1'b0;
			open_drive_o <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			force_v <= next_force_v;
			force_code <= next_force_code;
			travel_fault_o <= next_fault;
			command_done_ok_o <= next_done;
			close_drive_o <= next_state == ssp_pkg::ST_MOVE_CLOSE;
			open_drive_o <= next_state == ssp_pkg::ST_MOVE_OPEN;
		end
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pos_code_o <= ssp_pkg::POS_INDETERM;
			at_closed_o <= 1'b0;
			at_open_o <= 1'b0;
			in_transit_o <= 1'b1;
			disturbed_o <= 1'b0;
			one_contact_flag_o <= 1'b0;
		end else begin
			pos_code_o <= next_code;
			at_closed_o <= next_code == ssp_pkg::POS_CLOSED;
			at_open_o <= next_code == ssp_pkg::POS_OPEN;
			in_transit_o <= next_code == ssp_pkg::POS_INDETERM;
			disturbed_o <= next_code == ssp_pkg::POS_DISTURBED;
			one_contact_flag_o <= single;
		end
	end
	// ========================================
	// checks
	a_code_flags: assert property (@(posedge clock_i) disable iff (rst_i)
		(at_closed_o == (pos_code_o == ssp_pkg::POS_CLOSED)) &&
		(in_transit_o == (pos_code_o == ssp_pkg::POS_INDETERM)))
		else $error("position flags disagree with code");
	a_sync_agree: assert property (@(posedge clock_i) disable iff (rst_i)
		$changed(cl_in) |-> $past(cl_sync[2]) == $past(cl_sync[1]))
		else $error("contact change taken without agreement");
	a_close_start: assert property (@(posedge clock_i) disable iff (rst_i)
		start_close |=> close_drive_o && state == ssp_pkg::ST_MOVE_CLOSE && count == 32'h0)
		else $error("close command not started");
	a_interlock_blk: assert property (@(posedge clock_i) disable iff (rst_i)
		state == ssp_pkg::ST_IDLE && il_close && !auto_reclose_i && !start_open
		|=> !close_drive_o)
		else $error("interlocked close was driven");
	a_prot_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
		prot_open_i && !prot_block_i && !at_open_o && state != ssp_pkg::ST_MOVE_OPEN
		|=> open_drive_o)
		else $error("protection open not driven");
	a_drive_bound: assert property (@(posedge clock_i) disable iff (rst_i)
		state == ssp_pkg::ST_MOVE_CLOSE && expired(count, t_close) |=> !close_drive_o)
		else $error("close drive outlived travel time");
	a_drive_excl: assert property (@(posedge clock_i) disable iff (rst_i)
		!(close_drive_o && open_drive_o))
		else $error("both drives active");
	a_unwired_code: assert property (@(posedge clock_i) disable iff (rst_i)
		(cfg == 2'h0) [*2] |-> pos_code_o == ssp_pkg::POS_DISTURBED)
		else $error("unwired contacts not disturbed");
	a_done_notransit: assert property (@(posedge clock_i) disable iff (rst_i)
		command_done_ok_o && single |-> !in_transit_o && $past(state) != ssp_pkg::ST_IDLE)
		else $error("success pulse with transit shown");
	a_settle_transit: assert property (@(posedge clock_i) disable iff (rst_i)
		state == ssp_pkg::ST_SETTLE && next_state == ssp_pkg::ST_SETTLE |=> in_transit_o)
		else $error("settle not shown in transit");
endmodule

// *** ssp_switchgear_model.sv ***
// switchgear model: aux contacts follow the drive outputs after a travel delay
`timescale 1ns/1ns
module ssp_switchgear_model (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic close_drive_i,
	input wire logic open_drive_i,
	input wire logic [7:0] delay_i,
	input wire logic stall_i,
	output logic aux_closed_o,
	output logic aux_open_o
);
	// ========================================
	// mechanism
	logic closed;
	logic mid;
	logic [7:0] cnt;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			closed <= 1'b0;
			mid <= 1'b0;
			cnt <= 8'h00;
		end else if (close_drive_i || open_drive_i) begin
			// stall leaves the mechanism stuck between its end positions
			if (!stall_i && cnt >= delay_i) begin
				closed <= close_drive_i;
				mid <= 1'b0;
			end else begin
				mid <= 1'b1;
				cnt <= cnt + 8'h01;
			end
		end else begin
			cnt <= 8'h00;
		end
	end
	// between positions both contacts are open
	assign aux_closed_o = closed && !mid;
	assign aux_open_o = !closed && !mid;
endmodule

// *** ssp_supervisor_test.sv ***
// self-checking bench for the switchgear position supervisor
`timescale 1ns/1ns
module ssp_supervisor_test;
	logic clock_i = 0, rst_i = 1, read_i = 0, write_i = 0, stall = 0;
	logic [7:0] address_i = 8'h00, dly = 8'h03;
	logic [31:0] writedata_i = 32'h0, readdata_o, rdata;
	logic [3:0] byteenable_i = 4'hf;
	logic close_cmd_i = 0, open_cmd_i = 0, prot_open_i = 0, prot_block_i = 0, auto_reclose_i = 0;
	logic [2:0] interlock_close_i = 3'h0, interlock_open_i = 3'h0;
	logic waitrequest_o, at_closed_o, at_open_o, in_transit_o, disturbed_o, travel_fault_o;
	logic one_contact_flag_o, command_done_ok_o, close_drive_o, open_drive_o;
	logic aux_closed, aux_open;
	logic [1:0] pos_code_o, cfg = 2'h3;
	int n_fail = 0, checks_done = 0, dc, i;
	bit ok, tr;
	ssp_supervisor dut (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.aux_closed_i(aux_closed), .aux_open_i(aux_open), .close_cmd_i(close_cmd_i),
		.open_cmd_i(open_cmd_i), .prot_open_i(prot_open_i), .prot_block_i(prot_block_i),
		.auto_reclose_i(auto_reclose_i), .interlock_close_i(interlock_close_i),
		.interlock_open_i(interlock_open_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .pos_code_o(pos_code_o), .at_closed_o(at_closed_o),
		.at_open_o(at_open_o), .in_transit_o(in_transit_o), .disturbed_o(disturbed_o),
		.travel_fault_o(travel_fault_o), .one_contact_flag_o(one_contact_flag_o),
		.command_done_ok_o(command_done_ok_o), .close_drive_o(close_drive_o),
		.open_drive_o(open_drive_o));
	ssp_switchgear_model gear (.clock_i(clock_i), .rst_i(rst_i), .close_drive_i(close_drive_o),
		.open_drive_i(open_drive_o), .delay_i(dly), .stall_i(stall),
		.aux_closed_o(aux_closed), .aux_open_o(aux_open));
	initial forever #5 clock_i = !clock_i;
	// ========================================
	// expectations and reporting
	function automatic logic [1:0] exp_code(input logic [1:0] c, input logic cl, input logic op);
		case (c)
			2'h3: exp_code = (cl != op) ? {cl, op} : ssp_pkg::POS_DISTURBED;
			2'h1: exp_code = cl ? ssp_pkg::POS_CLOSED : ssp_pkg::POS_OPEN;
			2'h2: exp_code = op ? ssp_pkg::POS_OPEN : ssp_pkg::POS_CLOSED;
			default: exp_code = ssp_pkg::POS_DISTURBED;
		endcase
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_pos();
		logic [1:0] e;
		e = exp_code(cfg, aux_closed, aux_open);
		check("position", {e == 2'h3, e == 2'h1, e == 2'h2, e},
			{disturbed_o, at_open_o, at_closed_o, pos_code_o});
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ========================================
	// bus and command drivers
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int n;
		n = 0;
		address_i <= a;
		writedata_i <= d;
		byteenable_i <= be;
		write_i <= wr;
		read_i <= !wr;
		@(posedge clock_i);
		// only the watchdog ends a wait that never gets an answer
		while (waitrequest_o !== 1'b0) begin
			@(posedge clock_i);
			n++;
		end
		rdata = readdata_o;
		check("wait cycles", 1, n);
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic run_cmd(input int k);
		dc = 0;
		ok = 0;
		tr = 0;
		dly <= 8'(2 + $urandom % 8);
		case (k)
			0: close_cmd_i <= 1'b1;
			1: open_cmd_i <= 1'b1;
			2: prot_open_i <= 1'b1;
			default: auto_reclose_i <= 1'b1;
		endcase
		@(posedge clock_i);
		{close_cmd_i, open_cmd_i, prot_open_i, auto_reclose_i} <= 4'h0;
		repeat (60) begin
			@(posedge clock_i);
			if (close_drive_o === 1'b1 || open_drive_o === 1'b1) dc++;
			if (command_done_ok_o === 1'b1) ok = 1;
			if (in_transit_o === 1'b1) tr = 1;
			if (dc > 0 && close_drive_o === 1'b0 && open_drive_o === 1'b0) break;
		end
		repeat (6) @(posedge clock_i);
	endtask
	task automatic set_cfg(input logic [1:0] c);
		cfg = c;
		bus(1, ssp_pkg::ADDR_CFG, {30'h0, c}, 4'hf);
		repeat (3) @(posedge clock_i);
	endtask
	// ========================================
	// main sequence
	initial begin
		void'($urandom(40306));
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		bus(0, ssp_pkg::ADDR_CFG, 0, 4'hf);
		check("cfg reset", 32'h3, {30'h0, rdata[1:0]});
		bus(0, ssp_pkg::ADDR_T_CLOSE, 0, 4'hf);
		check("close preset", ssp_pkg::T_TRAVEL_RESET, rdata);
		bus(1, ssp_pkg::ADDR_T_SETTLE, 32'hffff_ff05, 4'h1);
		bus(0, ssp_pkg::ADDR_T_SETTLE, 0, 4'hf);
		check("settle preset", 32'h5, rdata);
		bus(1, ssp_pkg::ADDR_T_CLOSE, 32'h14, 4'hf);
		bus(1, ssp_pkg::ADDR_T_OPEN, 32'h14, 4'hf);
		bus(1, ssp_pkg::ADDR_STATUS, 32'h0, 4'hf);
		bus(0, ssp_pkg::ADDR_STATUS, 0, 4'hf);
		check("status code", exp_code(cfg, aux_closed, aux_open), rdata[1:0]);
		bus(0, 8'h20, 0, 4'hf);
		check("unmapped read", 32'h0, rdata);
		check_pos();
		$display("test registers done");
		for (i = 0; i < 3; i++) begin
			interlock_close_i <= 3'(1 << i);
			run_cmd(0);
			check("blocked close drive", 0, dc);
		end
		interlock_close_i <= 3'h0;
		interlock_open_i <= 3'(1 + $urandom % 7);
		run_cmd(0);
		check("close success", 32'h3, {ok, tr});
		check_pos();
		prot_block_i <= 1'b1;
		run_cmd(2);
		check("blocked trip drive", 0, dc);
		prot_block_i <= 1'b0;
		run_cmd(2);
		check("trip opens", ssp_pkg::POS_OPEN, pos_code_o);
		interlock_close_i <= 3'(1 + $urandom % 7);
		run_cmd(3);
		check("reclose closes", ssp_pkg::POS_CLOSED, pos_code_o);
		{interlock_close_i, interlock_open_i} <= 6'h00;
		stall <= 1'b1;
		run_cmd(1);
		check("open fault", 1, travel_fault_o);
		check("drive bounded", 1, dc <= 20);
		check_pos();
		stall <= 1'b0;
		$display("test both contacts done");
		set_cfg(2'h1);
		check("one contact", 1, one_contact_flag_o);
		check_pos();
		run_cmd(0);
		check("closed only success", 1, ok);
		check_pos();
		run_cmd(1);
		check("unsupervised open", 0, {ok, travel_fault_o});
		stall <= 1'b1;
		run_cmd(0);
		repeat (8) @(posedge clock_i);
		check("expiry fault", 1, travel_fault_o);
		check("after settle", ssp_pkg::POS_CLOSED, pos_code_o);
		stall <= 1'b0;
		set_cfg(2'h0);
		check_pos();
		set_cfg(2'h2);
		check_pos();
		run_cmd(1);
		check("open only success", 1, ok);
		check_pos();
		run_cmd(0);
		check("open only close", ssp_pkg::POS_CLOSED, pos_code_o);
		stall <= 1'b1;
		run_cmd(1);
		repeat (8) @(posedge clock_i);
		check("open expiry", 32'h5, {travel_fault_o, pos_code_o});
		stall <= 1'b0;
		$display("test single contact done");
		finish_test();
	end
	initial begin
		#400000;
		check("watchdog", 0, 1);
		finish_test();
	end
endmodule
